// >>> core/litd_pkg.sv
// constants, types and behaviour summary for the bus target
// Behaviour
// - while supply-good is low the bus side decodes and answers nothing
// - wake pins, infrared transmit and indicators keep working without supply-good
// - supply-good low disables the infrared half-duplex timeout
// - events are signalled by driving the open-drain active-low wake output
// - every register behind the bus is one byte, reached by I/O or DMA
// - only I/O write, I/O read, DMA write and DMA read, one byte each
// - unsupported cycle types are ignored and the shared lines stay undriven
// - after sampling the frame strobe the device releases the data lines next clock
// - state machines may idle while the bus is quiet, resuming on the frame strobe
// - at least one wait state is inserted before each I/O byte completes
// - I/O waits may be stretched as long as the internal function needs
// - the request output carries only the encoded DMA request
// - bus powerdown asserted puts the bus side into its idle, released state
// - the bus reset input resets all bus-side logic
// - no clock-run signalling; the bus clock is taken as free running
// - I/O waits use the long-wait code, three on reads, two on writes
// - DMA waits use the short-wait code, three on reads, four on writes
// - every I/O and DMA cycle starts with an all-zero start field
// - under bus reset ignore frames, float data lines, hold request output high
package litd_pkg;
    localparam logic [3:0] START_CODE   = 4'h0;
    localparam logic [1:0] TYPE_IO      = 2'h0;
    localparam logic [1:0] TYPE_DMA     = 2'h2;
    localparam int         DIR_BIT      = 1;
    localparam logic [3:0] SYNC_LONG    = 4'h6;
    localparam logic [3:0] SYNC_SHORT   = 4'h5;
    localparam logic [3:0] SYNC_READY   = 4'h0;
    localparam logic [3:0] TURN_CODE    = 4'hF;
    localparam logic [1:0] SIZE_BYTE    = 2'h0;
    localparam logic [2:0] WAIT_IO_RD   = 3'h3;
    localparam logic [2:0] WAIT_IO_WR   = 3'h2;
    localparam logic [2:0] WAIT_DMA_RD  = 3'h3;
    localparam logic [2:0] WAIT_DMA_WR  = 3'h4;
    localparam int         ADDR_NIBS    = 4;
    localparam int         REQ_BITS     = 5;
    localparam int         WAKE_SRCS    = 5;

    typedef struct packed {
        logic        write;
        logic        dma;
        logic [15:0] addr;
        logic [7:0]  data;
    } litd_req_t;
endpackage

// >>> core/litd_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module litd_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    generate
        if (WIDTH < 1) begin : bad_width
            $error("litd_sync2 width must be positive");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage <= '0;
            q     <= '0;
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule
`default_nettype wire

// >>> core/litd_dreq.sv
// serial encoder for the dma request line
`timescale 1ns/1ps
`default_nettype none
module litd_dreq #(
    parameter logic [2:0] CHANNEL = 3'h1
) (
    input  wire logic lpc_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic req,
    output var  logic ldrq_n
);
    logic                          prev;
    logic [litd_pkg::REQ_BITS-1:0] shift;
    logic [2:0]                    left;

    always_ff @(posedge lpc_clk) begin
        if (!rst_n || !enable) begin
            prev   <= 1'h0;
            shift  <= '1;
            left   <= 3'h0;
            ldrq_n <= 1'h1;
        end else if (left != 3'h0) begin
            ldrq_n <= shift[litd_pkg::REQ_BITS-1];
            shift  <= {shift[litd_pkg::REQ_BITS-2:0], 1'h1};
            left   <= left - 3'h1;
        end else begin
            ldrq_n <= 1'h1;
            if (req != prev) begin
                prev  <= req;
                shift <= {1'h0, CHANNEL, req}; // start, channel, active
                left  <= 3'(litd_pkg::REQ_BITS);
            end
        end
    end

    req_high_a: assert property (@(posedge lpc_clk) disable iff (!rst_n)
        !enable |=> ldrq_n) else $error("request line driven while disabled");
endmodule
`default_nettype wire

// >>> core/litd_target.sv
// bus target: frame decode, wait codes, crossing and wake logic
`timescale 1ns/1ps
`default_nettype none
module litd_target #(
    parameter logic [15:0] IO_BASE     = 16'h0300,
    parameter int          IO_SPAN     = 8,
    parameter logic [2:0]  DMA_CHANNEL = 3'h1
) (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 lpc_clk,
    input  wire logic                                 host_bus_reset_n,
    input  wire logic [3:0]                           lad_in,
    output var  logic [3:0]                           lad_out,
    output var  logic                                 lad_oe,
    input  wire logic                                 lframe_n,
    output var  logic                                 ldrq_n,
    input  wire logic                                 lpc_powerdown_n,
    input  wire logic                                 internal_supply_ok,
    output var  logic                                 wake_event_out_n,
    output var  logic                                 wake_event_oe,
    input  wire logic                                 keyboard_data_line,
    input  wire logic                                 mouse_data_line,
    input  wire logic                                 ring_indicate_first_n,
    input  wire logic                                 ring_indicate_second_n,
    input  wire logic                                 second_port_receive,
    input  wire logic                                 slow_clock_in,
    input  wire logic [litd_pkg::WAKE_SRCS-1:0]       wake_enable,
    input  wire logic                                 wake_clear,
    output var  logic                                 slow_clock_tick,
    input  wire logic                                 ir_tx_in,
    output var  logic                                 infrared_transmit,
    input  wire logic [1:0]                           led_in,
    output var  logic                                 indicator_out_first,
    output var  logic                                 indicator_out_second,
    output var  logic                                 ir_timeout_enable,
    input  wire logic                                 func_enable,
    input  wire logic                                 dma_request,
    output var  logic                                 req_valid,
    output var  litd_pkg::litd_req_t                  req,
    input  wire logic                                 rsp_valid,
    input  wire logic [7:0]                           rsp_data
);
    typedef enum logic [3:0] {
        L_IDLE, L_CT, L_ADDR, L_CHAN, L_SIZE, L_WDATA, L_TAR1, L_TAR2,
        L_SYNC, L_RDATA, L_BTAR, L_REL
    } litd_state_t;

    localparam int DIR_BIT_L = litd_pkg::DIR_BIT;

    generate
        if (IO_SPAN < 1 || int'(IO_BASE) + IO_SPAN > 65536) begin : bad_window
            $error("io window does not fit the 16-bit space");
        end
    endgenerate

    function automatic logic io_hit(input logic [15:0] a);
        io_hit = ({1'h0, a} >= {1'h0, IO_BASE})
              && ({1'h0, a} < 17'({1'h0, IO_BASE} + 17'(IO_SPAN)));
    endfunction

    function automatic logic type_ok(input logic [3:0] ct);
        type_ok = (ct[3:2] == litd_pkg::TYPE_IO) || (ct[3:2] == litd_pkg::TYPE_DMA);
    endfunction

    // bus-clock side
    litd_state_t         state;
    litd_pkg::litd_req_t cur;
    litd_pkg::litd_req_t xfer;
    logic                dev_sends;
    logic                claim;
    logic [1:0]          nib;
    logic [2:0]          nwait;
    logic [2:0]          wcnt;
    logic                issued;
    logic                req_tog;
    logic [7:0]          rdata;
    logic [4:0]          l_sync;
    logic                supply_l;
    logic                pd_l;
    logic                func_l;
    logic                dreq_l;
    logic                rsp_tog_l;
    logic                busy;
    logic                bus_live;

    // system-clock side
    logic [7:0]          c_sync;
    logic                supply_c;
    logic                req_tog_c;
    logic                req_tog_d;
    logic [5:0]          pins_d;
    logic                rsp_tog;
    logic                pend;
    logic [7:0]          rsp_hold;
    logic                wake_latched;
    logic [litd_pkg::WAKE_SRCS-1:0] wake_hit;

    litd_sync2 #(.WIDTH(5)) u_sync_l (
        .clk   (lpc_clk),
        .rst_n (host_bus_reset_n),
        .d     ({internal_supply_ok, lpc_powerdown_n, func_enable, dma_request, rsp_tog}),
        .q     (l_sync)
    );

    assign supply_l  = l_sync[4];
    assign pd_l      = l_sync[3];
    assign func_l    = l_sync[2];
    assign dreq_l    = l_sync[1];
    assign rsp_tog_l = l_sync[0];
    assign busy      = req_tog != rsp_tog_l;
    assign bus_live  = supply_l && pd_l;

    litd_dreq #(.CHANNEL(DMA_CHANNEL)) u_dreq (
        .lpc_clk (lpc_clk),
        .rst_n   (host_bus_reset_n),
        .enable  (bus_live),
        .req     (dreq_l),
        .ldrq_n  (ldrq_n)
    );

    // frame and field sequencing, bus clock taken as free running
    always_ff @(posedge lpc_clk) begin
        if (!host_bus_reset_n) begin
            state     <= L_IDLE;
            lad_out   <= 4'h0;
            lad_oe    <= 1'h0;
            cur       <= '0;
            dev_sends <= 1'h0;
            claim     <= 1'h0;
            nib       <= 2'h0;
            nwait     <= 3'h0;
            wcnt      <= 3'h0;
        end else if (!bus_live) begin
            state  <= L_IDLE;
            lad_oe <= 1'h0;
        end else if (!lframe_n) begin
            lad_oe <= 1'h0;
            nib    <= 2'h0;
            state  <= (lad_in == litd_pkg::START_CODE) ? L_CT : L_IDLE;
        end else begin
            case (state)
                L_IDLE: begin
                    lad_oe <= 1'h0;
                end
                L_CT: begin
                    if (type_ok(lad_in)) begin
                        cur.write <= lad_in[3] ? !lad_in[DIR_BIT_L] : lad_in[DIR_BIT_L];
                        cur.dma   <= lad_in[3];
                        dev_sends <= lad_in[3] ? lad_in[DIR_BIT_L] : !lad_in[DIR_BIT_L];
                        if (lad_in[3]) begin
                            nwait <= lad_in[DIR_BIT_L] ? litd_pkg::WAIT_DMA_WR
                                                       : litd_pkg::WAIT_DMA_RD;
                            state <= L_CHAN;
                        end else begin
                            nwait <= lad_in[DIR_BIT_L] ? litd_pkg::WAIT_IO_WR
                                                       : litd_pkg::WAIT_IO_RD;
                            state <= L_ADDR;
                        end
                    end else begin
                        state <= L_IDLE;
                    end
                end
                L_ADDR: begin
                    cur.addr <= {cur.addr[11:0], lad_in};
                    nib      <= nib + 2'h1;
                    if (nib == 2'(litd_pkg::ADDR_NIBS - 1)) begin
                        claim <= func_l && io_hit({cur.addr[11:0], lad_in});
                        nib   <= 2'h0;
                        state <= cur.write ? L_WDATA : L_TAR1;
                    end
                end
                L_CHAN: begin
                    cur.addr <= 16'h0000;
                    claim    <= (lad_in[2:0] == DMA_CHANNEL);
                    state    <= L_SIZE;
                end
                L_SIZE: begin
                    claim <= claim && (lad_in[1:0] == litd_pkg::SIZE_BYTE);
                    state <= dev_sends ? L_TAR1 : L_WDATA;
                end
                L_WDATA: begin
                    if (nib == 2'h0) begin
                        cur.data[3:0] <= lad_in;
                        nib           <= 2'h1;
                    end else begin
                        cur.data[7:4] <= lad_in;
                        nib           <= 2'h0;
                        state         <= L_TAR1;
                    end
                end
                L_TAR1: begin
                    state <= L_TAR2;
                end
                L_TAR2: begin
                    if (claim) begin
                        lad_out <= cur.dma ? litd_pkg::SYNC_SHORT : litd_pkg::SYNC_LONG;
                        lad_oe  <= 1'h1;
                        wcnt    <= 3'h0;
                        state   <= L_SYNC;
                    end else begin
                        state <= L_IDLE;
                    end
                end
                L_SYNC: begin
                    // long-wait code may be held until the function answers
                    if ((4'(wcnt) + 4'h1 >= 4'(nwait)) && issued && !busy) begin
                        lad_out <= litd_pkg::SYNC_READY;
                        state   <= dev_sends ? L_RDATA : L_BTAR;
                    end else if (4'(wcnt) + 4'h1 < 4'(nwait)) begin
                        wcnt <= wcnt + 3'h1;
                    end
                end
                L_RDATA: begin
                    if (nib == 2'h0) begin
                        lad_out <= rdata[3:0];
                        nib     <= 2'h1;
                    end else begin
                        lad_out <= rdata[7:4];
                        nib     <= 2'h0;
                        state   <= L_BTAR;
                    end
                end
                L_BTAR: begin
                    lad_out <= litd_pkg::TURN_CODE;
                    state   <= L_REL;
                end
                L_REL: begin
                    lad_oe <= 1'h0;
                    state  <= L_IDLE;
                end
                default: begin
                    lad_oe <= 1'h0;
                    state  <= L_IDLE;
                end
            endcase
        end
    end

    // request handshake toward the internal functions
    always_ff @(posedge lpc_clk) begin
        if (!host_bus_reset_n) begin
            issued  <= 1'h0;
            req_tog <= 1'h0;
            xfer    <= '0;
            rdata   <= 8'h00;
        end else if (state == L_TAR2) begin
            issued <= 1'h0;
        end else if (state == L_SYNC && !issued && !busy) begin
            issued  <= 1'h1;
            req_tog <= ~req_tog;
            xfer    <= cur;
        end else if (state == L_SYNC && issued && !busy) begin
            rdata <= rsp_hold;
        end
    end

    litd_sync2 #(.WIDTH(8)) u_sync_c (
        .clk   (clk),
        .rst_n (reset_n),
        .d     ({internal_supply_ok, req_tog, slow_clock_in, second_port_receive,
                 ring_indicate_second_n, ring_indicate_first_n, mouse_data_line,
                 keyboard_data_line}),
        .q     (c_sync)
    );

    assign supply_c  = c_sync[7];
    assign req_tog_c = c_sync[6];
    assign wake_hit  = pins_d[4:0] & ~c_sync[4:0] & wake_enable;

    // request delivery and response capture
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            req_tog_d <= 1'h0;
            req_valid <= 1'h0;
            req       <= '0;
            pend      <= 1'h0;
            rsp_tog   <= 1'h0;
            rsp_hold  <= 8'h00;
        end else begin
            req_tog_d <= req_tog_c;
            req_valid <= req_tog_c != req_tog_d;
            if (req_tog_c != req_tog_d) begin
                req  <= xfer;
                pend <= 1'h1;
            end else if (rsp_valid && pend) begin
                rsp_hold <= rsp_data;
                rsp_tog  <= ~rsp_tog;
                pend     <= 1'h0;
            end
        end
    end

    // wake events, kept alive without supply-good
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pins_d           <= 6'h00;
            wake_latched     <= 1'h0;
            wake_event_out_n <= 1'h1;
            wake_event_oe    <= 1'h0;
            slow_clock_tick  <= 1'h0;
        end else begin
            pins_d           <= c_sync[5:0];
            wake_latched     <= (wake_latched && !wake_clear) || (|wake_hit);
            wake_event_out_n <= !wake_latched;
            wake_event_oe    <= wake_latched;
            slow_clock_tick  <= c_sync[5] && !pins_d[5];
        end
    end

    // trickle-powered outputs and infrared timeout gate
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            infrared_transmit    <= 1'h0;
            indicator_out_first  <= 1'h0;
            indicator_out_second <= 1'h0;
            ir_timeout_enable    <= 1'h0;
        end else begin
            infrared_transmit    <= ir_tx_in;
            indicator_out_first  <= led_in[0];
            indicator_out_second <= led_in[1];
            ir_timeout_enable    <= supply_c;
        end
    end

    sequence io_rd_sync_s;
        state == L_TAR2 && claim && lframe_n && bus_live && !cur.dma && dev_sends;
    endsequence

    sequence dma_wr_sync_s;
        state == L_TAR2 && claim && lframe_n && bus_live && cur.dma && dev_sends;
    endsequence

    frame_release_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        !lframe_n |=> !lad_oe) else $error("data lines driven after frame strobe");

    supply_gate_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        !supply_l |=> !lad_oe && state == L_IDLE) else $error("bus active without supply");

    bad_type_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        state == L_CT && lframe_n && bus_live && !type_ok(lad_in)
        |=> !lad_oe[*2]) else $error("unsupported cycle was answered");

    io_code_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        state == L_SYNC && !cur.dma |-> lad_out == litd_pkg::SYNC_LONG)
        else $error("wrong wait code on io cycle");

    io_rd_waits_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        io_rd_sync_s |=> (lframe_n && lad_out == litd_pkg::SYNC_LONG)[*3] or
        (##[1:3] !lframe_n)) else $error("io read gave fewer than three waits");

    dma_wr_waits_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        dma_wr_sync_s |=> (lframe_n && lad_out == litd_pkg::SYNC_SHORT)[*4] or
        (##[1:4] !lframe_n)) else $error("dma write gave fewer than four waits");

    ready_after_wait_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        $past(state) == L_SYNC && state != L_SYNC && lad_oe
        |-> $past(lad_out) != litd_pkg::SYNC_READY) else $error("ready without wait");

    no_claim_a: assert property (@(posedge lpc_clk) disable iff (!host_bus_reset_n)
        state == L_TAR2 && !claim |=> !lad_oe) else $error("unclaimed cycle driven");

    wake_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        (|wake_hit) |=> ##1 (wake_event_oe && !wake_event_out_n))
        else $error("wake event not signalled");

    ir_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        !supply_c |=> !ir_timeout_enable) else $error("ir timeout left enabled");
endmodule
`default_nettype wire

// >>> core/placeholder_end.sv
// reserved unit; holds no logic

// >>> verification/litd_host_model.sv
// host controller model framing cycles on the shared lines
`timescale 1ns/1ps
`default_nettype none
module litd_host_model (
    input  wire logic       lpc_clk,
    input  wire logic [3:0] lad_out,
    input  wire logic       lad_oe,
    output var  logic [3:0] lad_in,
    output var  logic       lframe_n
);
    logic [3:0] drv = 4'hF;
    logic       oe = 1'b0;
    // released lines are pulled up
    always_comb lad_in = lad_oe ? lad_out : (oe ? drv : 4'hF);
    initial lframe_n = 1'b1;
    task automatic nib(input logic [3:0] v, input logic f);
        @(negedge lpc_clk) {drv, oe, lframe_n} = {v, 1'b1, f};
    endtask
    task automatic cycle(input logic [3:0] ct, input logic [15:0] a, input logic [7:0] wd,
                         output logic [3:0] code, output int nw, output logic [7:0] rd);
        code = 4'hF;
        nw = 0;
        nib(4'h0, 1'b0);
        nib(ct, 1'b1);
        for (int i = 3; i >= (ct[3] ? 2 : 0); i--) nib(ct[3] ? {3'h0, i == 3} : a[4*i+:4], 1'b1);
        if (ct[3] != ct[1]) for (int i = 0; i < 2; i++) nib(wd[4*i+:4], 1'b1);
        nib(4'hF, 1'b1);
        @(negedge lpc_clk) oe = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge lpc_clk);
            if (lad_oe !== 1'b1 || lad_in === 4'h0) break;
            code = lad_in;
            nw++;
        end
        if (nw > 0 && ct[3] == ct[1]) repeat (2) @(negedge lpc_clk) rd = {lad_in, rd[7:4]};
        repeat (4) @(negedge lpc_clk);
    endtask
endmodule
`default_nettype wire

// >>> verification/litd_target_tb_top.sv
// self-checking bench for the bus target
`timescale 1ns/1ps
`default_nettype none
module litd_target_tb_top;
    logic clk = 1'b0, lpc_clk = 1'b0, rsp_valid = 1'b0, reset_n, host_bus_reset_n, lframe_n;
    logic lad_oe, ldrq_n, lpc_powerdown_n, internal_supply_ok, wake_event_out_n, wake_event_oe;
    logic keyboard_data_line, mouse_data_line, ring_indicate_first_n, ring_indicate_second_n;
    logic second_port_receive, slow_clock_in, slow_clock_tick, wake_clear, ir_tx_in, req_valid;
    logic infrared_transmit, indicator_out_first, indicator_out_second, ir_timeout_enable;
    logic func_enable, dma_request, w;
    logic [3:0] lad_in, lad_out, code, bits, ct;
    logic [4:0] wake_enable;
    logic [1:0] led_in;
    logic [7:0] rsp_data, rd;
    litd_pkg::litd_req_t req, cap;
    int n_mismatch = 0, checked = 0, n_req = 0, dly = 0, n_tick = 0, nw, n0;
    litd_target litd_target_i (.*);
    litd_host_model litd_host_model_i (.*);
    initial forever #2 clk = ~clk;
    initial #37 forever #80 lpc_clk = ~lpc_clk;
    // user side answers each request three cycles later
    always @(negedge clk) begin
        rsp_valid <= (dly == 1);
        dly <= (req_valid === 1'b1) ? 3 : (dly > 0 ? dly - 1 : 0);
        n_req <= n_req + (req_valid === 1'b1);
        n_tick <= n_tick + (slow_clock_tick === 1'b1);
        cap <= (req_valid === 1'b1) ? req : cap;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_cycles();
        for (int k = 0; k < 4; k++) begin
            ct = {k[1], 1'b0, k[1] == k[0], 1'b0};
            w = ct[3] != ct[1];
            @(negedge clk) rsp_data = 8'h3C + k;
            litd_host_model_i.cycle(ct, 16'h0301 + k, 8'hA5 + k, code, nw, rd);
            chk("sync", ct[3] ? 4'h5 : 4'h6, code);
            chk("waits", 1, nw >= (k == 0 ? 2 : (k == 3 ? 4 : 3)));
            chk("kind", {w, ct[3]}, {cap.write, cap.dma});
            chk("byte", w ? 8'hA5 + k : 8'h3C + k, w ? cap.data : rd);
            if (k < 2) chk("addr", 16'h0301 + k, cap.addr);
        end
        @(negedge clk) dma_request = 1'b1;
        for (int i = 0; i < 12 && ldrq_n !== 1'b0; i++) @(negedge lpc_clk);
        repeat (4) @(negedge lpc_clk) bits = {bits[2:0], ldrq_n};
        chk("ldrq", 4'b0011, bits);
        chk("ir timeout on", 1'b1, ir_timeout_enable);
        $display("test of cycle kinds and request line done");
    endtask
    task automatic t_power();
        n0 = n_req;
        for (int k = 0; k < 5; k++) begin
            @(negedge clk) {func_enable, lpc_powerdown_n, internal_supply_ok} = {k != 2, k != 3, k != 4};
            repeat (4) @(negedge lpc_clk);
            litd_host_model_i.cycle(k == 0 ? 4'h4 : 4'h0, k == 1 ? 16'h0308 : 16'h0301,
                                    8'h00, code, nw, rd);
            chk("unclaimed", 4'hF, code);
        end
        chk("no request", n0, n_req);
        chk("ir timeout", 1'b0, ir_timeout_enable);
        @(negedge clk) {ir_tx_in, led_in, wake_enable, keyboard_data_line} = 9'h182;
        repeat (12) @(negedge clk);
        chk("wake", 2'b10, {wake_event_oe, wake_event_out_n});
        chk("pins", 3'b110, {infrared_transmit, indicator_out_second, indicator_out_first});
        {wake_clear, keyboard_data_line} = 2'b11;
        @(negedge clk) wake_clear = 1'b0;
        repeat (4) @(negedge clk);
        chk("wake clear", 1'b0, wake_event_oe);
        n0 = n_tick;
        slow_clock_in = 1'b0;
        repeat (4) @(negedge clk);
        slow_clock_in = 1'b1;
        repeat (6) @(negedge clk);
        chk("slow tick", n0 + 1, n_tick);
        $display("test of supply and decode gating done");
    endtask
    initial begin
        {reset_n, host_bus_reset_n, lpc_powerdown_n, internal_supply_ok, func_enable} = 5'b00111;
        {dma_request, wake_clear, ir_tx_in, led_in, wake_enable, rsp_data} = '0;
        {keyboard_data_line, mouse_data_line, ring_indicate_first_n, ring_indicate_second_n,
         second_port_receive, slow_clock_in} = 6'h3F;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge lpc_clk);
        chk("bus reset", 2'b10, {ldrq_n, lad_oe});
        host_bus_reset_n = 1'b1;
        repeat (4) @(negedge lpc_clk);
        t_cycles();
        t_power();
        print_verdict();
    end
    initial begin
        #300000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
